// >>> core/frame_timer_pkg.sv
// Package of offsets, field layouts and reset values for the frame timer.
`default_nettype none
package frame_timer_pkg;
   localparam logic [7:0]  INTERVAL_OFFSET = 8'h34;
   localparam logic [7:0]  REMAINING_OFFSET = 8'h38;
   localparam int          TOGGLE_BIT = 31;
   localparam int          BUDGET_MSB = 30;
   localparam int          BUDGET_LSB = 16;
   localparam int          COUNT_MSB = 13;
   localparam logic [13:0] PERIOD_RESET = 14'h2edf; // 11,999 bit times.
   localparam logic [14:0] BUDGET_RESET = 15'h0000;
   localparam logic [13:0] COUNT_ZERO = 14'h0000;
   localparam logic [13:0] COUNT_ONE = 14'h0001;
   localparam logic [31:0] READ_ZERO = 32'h0000_0000;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_RUN  = 1'b1
   } run_state_type;
endpackage : frame_timer_pkg
`default_nettype wire

// >>> core/usb_host_frame_interval_timer.sv
// Frame interval register and frame remaining down counter of a USB host.
`default_nettype none
module usb_host_frame_interval_timer
   import frame_timer_pkg::*;
(
   input  wire logic        ref_clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        bit_tick_in,
   input  wire logic        running_state_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   input  wire logic [7:0]  reg_addr_in,
   input  wire logic [31:0] reg_wdata_in,
   output logic [31:0]      reg_rdata_out,
   output logic             frame_start_out,
   output logic [14:0]      packet_budget_count_out
);

   ////////////////////////////////////////////////////////////////////////
   // Storage.
   logic [13:0]   frame_period_bits;
   logic [14:0]   fs_packet_bit_budget;
   logic          period_update_toggle;
   logic [13:0]   bits_left_count;
   logic          period_toggle_copy;
   logic          run_d1;
   logic          run_d2;
   run_state_type state;
   logic          enter_run;
   logic          reload;

   // Address match shared by write and read decode.
   // The full byte is compared, so no other offset aliases a register.
   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      hit = (a == o);
   endfunction : hit

   // The running-state level may come from another clock, so sync it.
   // Only the second flop is read, so a metastable first stage never leaks.
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         run_d1 <= 1'b0;
         run_d2 <= 1'b0;
      end else begin
         run_d1 <= running_state_in;
         run_d2 <= run_d1;
      end
   end

   // Tracks whether the controller runs, to find the entry edge.
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state <= ST_IDLE;
      end else begin
         case (state)
            ST_IDLE: state <= run_d2 ? ST_RUN : ST_IDLE;
            ST_RUN:  state <= run_d2 ? ST_RUN : ST_IDLE;
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Entry is the first cycle that sees the synchronised level high.
   assign enter_run = (state == ST_IDLE) && run_d2;
   // Counter at zero reloads on the next bit time while running.
   assign reload = (state == ST_RUN) && bit_tick_in
                   && (bits_left_count == COUNT_ZERO);

   ////////////////////////////////////////////////////////////////////////
   // Interval register; reserved bits are dropped on write.
   // The budget is kept as written; hardware never works it out itself.
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         frame_period_bits    <= PERIOD_RESET;
         fs_packet_bit_budget <= BUDGET_RESET;
         period_update_toggle <= 1'b0;
      end else if (reg_wr_in && hit(reg_addr_in, INTERVAL_OFFSET)) begin
         period_update_toggle <= reg_wdata_in[TOGGLE_BIT];
         fs_packet_bit_budget <= reg_wdata_in[BUDGET_MSB:BUDGET_LSB];
         frame_period_bits    <= reg_wdata_in[COUNT_MSB:0];
      end
   end

   // Remaining counter. A period write is only read at entry or reload, so
   // it never cuts short or stretches the running frame; a remaining preset can.
   // Entry outranks a preset in its cycle, so the first frame always starts from a full period.
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         bits_left_count    <= COUNT_ZERO;
         period_toggle_copy <= 1'b0;
      end else if (enter_run) begin
         bits_left_count <= frame_period_bits;
      end else if (reload) begin
         bits_left_count    <= frame_period_bits;
         period_toggle_copy <= period_update_toggle;
      end else if (state == ST_RUN && bit_tick_in) begin
         bits_left_count <= bits_left_count - COUNT_ONE;
      end else if (reg_wr_in && hit(reg_addr_in, REMAINING_OFFSET)) begin
         // A software preset lands unless entry, reload or a running tick takes the cycle; an idle tick does not block it.
         bits_left_count    <= reg_wdata_in[COUNT_MSB:0];
         period_toggle_copy <= reg_wdata_in[TOGGLE_BIT];
      end
   end

   // Frame start pulse and per-frame packet budget load.
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         frame_start_out         <= 1'b0;
         packet_budget_count_out <= BUDGET_RESET;
      end else begin
         frame_start_out <= reload;
         if (reload) begin
            packet_budget_count_out <= fs_packet_bit_budget;
         end
      end
   end

   // Registered read data; unmapped offsets read zero.
   // Reserved bits read as zero whatever software wrote there.
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         reg_rdata_out <= READ_ZERO;
      end else if (reg_rd_in && hit(reg_addr_in, INTERVAL_OFFSET)) begin
         reg_rdata_out <= {period_update_toggle, fs_packet_bit_budget,
                           2'h0, frame_period_bits};
      end else if (reg_rd_in && hit(reg_addr_in, REMAINING_OFFSET)) begin
         reg_rdata_out <= {period_toggle_copy, 17'h00000, bits_left_count};
      end else begin
         reg_rdata_out <= READ_ZERO;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks.
   // All checks but the reset value one are off while reset is low.
   reload_value_a: assert property (@(posedge ref_clk_in)
      disable iff (!rst_n_in) reload && !enter_run
      |=> bits_left_count == $past(frame_period_bits))
      else $error("Counter did not reload the period at zero.");
   count_down_a: assert property (@(posedge ref_clk_in)
      disable iff (!rst_n_in)
      state == ST_RUN && bit_tick_in && bits_left_count != COUNT_ZERO
      && !enter_run |=> bits_left_count == $past(bits_left_count) - 14'h1)
      else $error("Counter did not step down by one.");
   toggle_copy_a: assert property (@(posedge ref_clk_in)
      disable iff (!rst_n_in)
      reload |=> period_toggle_copy == $past(period_update_toggle))
      else $error("Toggle not copied at zero.");
   enter_load_a: assert property (@(posedge ref_clk_in)
      disable iff (!rst_n_in)
      enter_run |=> bits_left_count == $past(frame_period_bits))
      else $error("Entry did not load the period.");
   budget_load_a: assert property (@(posedge ref_clk_in)
      disable iff (!rst_n_in)
      reload |=> frame_start_out
      && packet_budget_count_out == $past(fs_packet_bit_budget))
      else $error("Budget not loaded at frame start.");
   period_hold_a: assert property (@(posedge ref_clk_in)
      disable iff (!rst_n_in)
      reg_wr_in && hit(reg_addr_in, INTERVAL_OFFSET) && !reload
      && !enter_run && state == ST_RUN && !bit_tick_in
      |=> $stable(bits_left_count))
      else $error("Period write disturbed the running count.");
   field_map_a: assert property (@(posedge ref_clk_in)
      disable iff (!rst_n_in)
      reg_wr_in && hit(reg_addr_in, INTERVAL_OFFSET)
      |=> frame_period_bits == $past(reg_wdata_in[13:0])
      && fs_packet_bit_budget == $past(reg_wdata_in[30:16]))
      else $error("Interval fields mapped wrongly.");
   reset_period_a: assert property (@(posedge ref_clk_in)
      $rose(rst_n_in) |-> frame_period_bits == 14'h2edf)
      else $error("Period not nominal after reset.");
   // Ticks while idle must leave the count alone; only entry or a
   // software write to the remaining register may change it there.
   idle_hold_a: assert property (@(posedge ref_clk_in)
      disable iff (!rst_n_in)
      state == ST_IDLE && !enter_run
      && !(reg_wr_in && hit(reg_addr_in, REMAINING_OFFSET))
      |=> $stable(bits_left_count))
      else $error("Count moved while the controller was idle.");
   // The remaining toggle only follows the update toggle at a reload.
   toggle_hold_a: assert property (@(posedge ref_clk_in)
      disable iff (!rst_n_in)
      !reload && !(reg_wr_in && hit(reg_addr_in, REMAINING_OFFSET))
      |=> $stable(period_toggle_copy))
      else $error("Remaining toggle changed outside a reload.");
   // Reserved bits of the remaining register always read as zero.
   spare_zero_a: assert property (@(posedge ref_clk_in)
      disable iff (!rst_n_in)
      reg_rd_in && hit(reg_addr_in, REMAINING_OFFSET)
      |=> reg_rdata_out[30:14] == 17'h00000)
      else $error("Reserved remaining bits read as nonzero.");
   // Read data falls back to zero once the read strobe drops.
   read_idle_a: assert property (@(posedge ref_clk_in)
      disable iff (!rst_n_in)
      !reg_rd_in |=> reg_rdata_out == READ_ZERO)
      else $error("Read data stood without a read strobe.");

   // Scenarios the bench is expected to reach.
   frame_seen_c: cover property (@(posedge ref_clk_in) reload);
   enter_seen_c: cover property (@(posedge ref_clk_in) enter_run);
   toggle_seen_c: cover property (@(posedge ref_clk_in)
      reload && period_update_toggle != period_toggle_copy);
   mid_write_c: cover property (@(posedge ref_clk_in)
      reg_wr_in && hit(reg_addr_in, INTERVAL_OFFSET) && state == ST_RUN);

endmodule : usb_host_frame_interval_timer
`default_nettype wire

// >>> test/usb_host_frame_interval_timer_bench.sv
// Self-checking bench for the frame interval register and remaining counter.
`default_nettype none
module usb_host_frame_interval_timer_bench
   import frame_timer_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk_in;
   logic        rst_n_in;
   logic        bit_tick_in;
   logic        running_state_in;
   logic        reg_wr_in;
   logic        reg_rd_in;
   logic [7:0]  reg_addr_in;
   logic [31:0] reg_wdata_in;
   logic [31:0] reg_rdata_out;
   logic        frame_start_out;
   logic [14:0] packet_budget_count_out;
   int          fail_count = 0;
   int          checks = 0;
   int          cycles = 0;
   int          frames = 0;
   int          first_frames;
   logic [31:0] saved;
   usb_host_frame_interval_timer uut (.ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in), .bit_tick_in(bit_tick_in),
      .running_state_in(running_state_in), .reg_wr_in(reg_wr_in),
      .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
      .frame_start_out(frame_start_out),
      .packet_budget_count_out(packet_budget_count_out));
   ////////////////////////////////////////////////////////////////////////
   // Clock at 20 ns; the cycle ceiling cuts a hung run short.
   initial begin
      ref_clk_in = 1'b0;
      forever #10 ref_clk_in = ~ref_clk_in;
   end
   always @(posedge ref_clk_in) begin
      cycles++;
      if (frame_start_out === 1'b1) frames++;
      if (cycles == 3000) begin
         fail_count++;
         close_out();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Comparison, verdict and access tasks; inputs move 1 ns after the edge.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic close_out();
      if (fail_count == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : close_out
   task automatic rd_check(input logic [7:0] a, input logic [31:0] exp);
      @(posedge ref_clk_in) #1;
      reg_rd_in = 1'b1;
      reg_addr_in = a;
      @(posedge ref_clk_in) #1;
      reg_rd_in = 1'b0;
      check(reg_rdata_out, exp);
   endtask : rd_check
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk_in) #1;
      reg_wr_in = 1'b1;
      reg_addr_in = a;
      reg_wdata_in = d;
      @(posedge ref_clk_in) #1;
      reg_wr_in = 1'b0;
   endtask : wr
   // Ticks are spaced two cycles apart, well inside the allowed spacing.
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge ref_clk_in) #1;
         bit_tick_in = 1'b1;
         @(posedge ref_clk_in) #1;
         bit_tick_in = 1'b0;
      end
   endtask : tick
   ////////////////////////////////////////////////////////////////////////
   // Main sequence: reset values, field layout, entry, countdown, reload.
   initial begin
      {rst_n_in, bit_tick_in, running_state_in, reg_wr_in, reg_rd_in} = '0;
      reg_addr_in = 8'h00;
      reg_wdata_in = 32'h0000_0000;
      repeat (12) @(posedge ref_clk_in);
      #1 rst_n_in = 1'b1;
      rd_check(INTERVAL_OFFSET, 32'h0000_2edf);
      rd_check(8'h3c, 32'h0000_0000);
      tick(1);
      rd_check(REMAINING_OFFSET, 32'h0000_0000);
      // Each new period flips the toggle; reserved bits are written as zero.
      wr(INTERVAL_OFFSET, 32'h9234_0006);
      rd_check(INTERVAL_OFFSET, 32'h9234_0006);
      wr(INTERVAL_OFFSET, 32'h1234_0005);
      rd_check(INTERVAL_OFFSET, 32'h1234_0005);
      running_state_in = 1'b1;
      repeat (6) @(posedge ref_clk_in);
      rd_check(REMAINING_OFFSET, 32'h0000_0005);
      check({17'h0, packet_budget_count_out}, 32'h0000_0000);
      tick(3);
      rd_check(REMAINING_OFFSET, 32'h0000_0002);
      wr(INTERVAL_OFFSET, 32'h9234_0007);
      rd_check(REMAINING_OFFSET, 32'h0000_0002);
      tick(2);
      rd_check(REMAINING_OFFSET, 32'h0000_0000);
      first_frames = frames;
      tick(1);
      rd_check(REMAINING_OFFSET, 32'h8000_0007);
      repeat (2) @(posedge ref_clk_in);
      #1;
      check(32'(frames - first_frames), 32'h0000_0001);
      check({17'h0, packet_budget_count_out}, 32'h0000_1234);
      // Controller reset mid-run: software saves the period and restores it.
      rd_check(INTERVAL_OFFSET, 32'h9234_0007);
      saved = reg_rdata_out;
      running_state_in = 1'b0;
      @(posedge ref_clk_in) #1;
      rst_n_in = 1'b0;
      @(posedge ref_clk_in) #1;
      rst_n_in = 1'b1;
      rd_check(INTERVAL_OFFSET, 32'h0000_2edf);
      wr(INTERVAL_OFFSET, saved);
      rd_check(INTERVAL_OFFSET, 32'h9234_0007);
      check({17'h0, packet_budget_count_out}, 32'h0000_0000);
      // An idle controller takes a preset of the remaining register.
      wr(REMAINING_OFFSET, 32'h8000_0123);
      rd_check(REMAINING_OFFSET, 32'h8000_0123);
      close_out();
   end
endmodule : usb_host_frame_interval_timer_bench
`default_nettype wire
